// ---- dv/compare_match_timer_channel_bench.sv ----
/* Self-checking bench for the timer channel.
   Assumes the checker is bound to the channel. */
`timescale 1ns/1ps

module compare_match_timer_channel_bench;
   import match_timer_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   bus_req_type bus_req = '0;
   logic [15:0] rdata;
   logic        capture_in = 1'b0;
   logic        irq;
   logic [15:0] v;
   logic [15:0] d;
   logic [31:0] seed = 32'h0000001b;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          t;
   logic [15:0] ra [5] = '{OFS_COUNTER, OFS_COMPARE, OFS_EVT_STATUS, OFS_IRQ_ENABLE, 16'hf0fe};
   logic [15:0] rv [5] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000};

   match_timer_channel u_match_timer_channel (
      .ref_clk, .reset, .bus_req, .rdata, .capture_in, .match_a_irq_request(irq)
   );

   always #5 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // The strobe drops one edge before the next request, so no signal is set twice at once.
   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      bus_req.addr  <= a;
      bus_req.wdata <= w;
      bus_req.wr    <= 1'b1;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] r);
      bus_req.addr <= a;
      bus_req.rd   <= 1'b1;
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1 r = rdata;
      @(posedge ref_clk);
   endtask

   task automatic wrd(input logic [15:0] a, input logic [15:0] w, output logic [15:0] r);
      bus_req.addr  <= a;
      bus_req.wdata <= w;
      bus_req.wr    <= 1'b1;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b1;
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1 r = rdata;
      @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      foreach (ra[i]) begin
         rd(ra[i], v);
         chk(v, rv[i]);
      end
      repeat (16) begin
         d = rnd();
         wrd(d[0] ? OFS_COMPARE : OFS_COUNTER, d, v);
         chk(v, d);
         wrd(OFS_IRQ_ENABLE, d, v);
         chk(v & 16'h0001, d & 16'h0001);
      end
      $display("done registers");
      wr(OFS_COMPARE, 16'h0002);
      wr(OFS_COUNTER, 16'h0000);
      wr(OFS_CLK_CTRL, 16'h0026);
      wr(OFS_IRQ_ENABLE, 16'h0001);
      wr(OFS_RUN_CTRL, 16'h0002);
      t = cyc;
      while (irq !== 1'b1) @(posedge ref_clk);
      chk(16'(cyc - t > 255 && cyc - t < 780), 16'h0001);
      t = cyc;
      rd(OFS_EVT_STATUS, v);
      chk(v & 16'h0001, 16'h0001);
      wr(OFS_EVT_STATUS, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      wr(OFS_EVT_STATUS, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      while (irq !== 1'b1) @(posedge ref_clk);
      chk(16'(cyc - t), 16'h0300);
      wr(OFS_RUN_CTRL, 16'h0000);
      rd(OFS_COUNTER, v);
      repeat (600) @(posedge ref_clk);
      rd(OFS_COUNTER, d);
      chk(d, v);
      rd(OFS_EVT_STATUS, v);
      wr(OFS_EVT_STATUS, 16'h0000);
      $display("done compare");
      wr(OFS_MODE_CTRL, 16'h0001);
      wr(OFS_CLK_CTRL, 16'h0000);
      wr(OFS_RUN_CTRL, 16'h0002);
      wr(OFS_COUNTER, 16'h8000);
      chk({15'h0, irq}, 16'h0000);
      capture_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk({15'h0, irq}, 16'h0001);
      rd(OFS_COMPARE, v);
      rd(OFS_COUNTER, d);
      chk(16'(v > 16'h7fff && d - v < 16'h0020), 16'h0001);
      wrd(OFS_COUNTER, 16'hffff, v);
      chk(16'(v - 16'hffff < 16'h0002), 16'h0001);
      rd(OFS_COUNTER, v);
      chk(16'(v < 16'h0008), 16'h0001);
      capture_in <= 1'b0;
      $display("done capture");
      wrap_up();
   end
endmodule // compare_match_timer_channel_bench

// ---- dv/match_timer_assertions.sv ----
/* Assertions on the ports of the timer channel.
   Assumes one clock and the register port of the package. */
`timescale 1ns/1ps

module match_timer_checker (
   input wire logic                         ref_clk,
   input wire logic                         reset,
   input wire match_timer_pkg::bus_req_type bus_req,
   input wire logic [15:0]                  rdata,
   input wire logic                         capture_in,
   input wire logic                         match_a_irq_request
);
   import match_timer_pkg::*;
   logic en_r;
   logic cap_r;
   wire  irq = match_a_irq_request;
   wire  wrs = bus_req.wr && bus_req.addr == OFS_EVT_STATUS;
   wire  rds = bus_req.rd && bus_req.addr == OFS_EVT_STATUS;
   wire  wcn = bus_req.wr && bus_req.addr == OFS_COUNTER;
   wire  rcn = bus_req.rd && bus_req.addr == OFS_COUNTER;

   // Shadow copies of the enable and mode bits, as only the ports are visible.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         en_r  <= 1'b0;
         cap_r <= 1'b0;
      end else begin
         if (bus_req.wr && bus_req.addr == OFS_IRQ_ENABLE) en_r <= bus_req.wdata[0];
         if (bus_req.wr && bus_req.addr == OFS_MODE_CTRL) cap_r <= bus_req.wdata[0];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence saw_flag;
      rds ##1 rdata[0];
   endsequence
   sequence counter_write_read;
      wcn ##1 rcn;
   endsequence

   a_rdata_idle_zero: assert property (
      !$past(bus_req.rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_irq_needs_enable: assert property (!en_r |-> !irq)
      else $error("request without enable");
   a_irq_holds: assert property (irq && !bus_req.wr |=> irq)
      else $error("request fell without a write");
   a_one_ignored: assert property (irq && wrs && bus_req.wdata[0] |=> irq)
      else $error("writing one cleared the flag");
   a_status_flag: assert property (irq && rds |=> rdata[0])
      else $error("status read missed the flag");
   a_clear_drops: assert property (
      saw_flag ##[1:20] (wrs && !bus_req.wdata[0]) |=> !irq)
      else $error("flag not cleared");
   a_write_wins: assert property (
      counter_write_read |=> rdata - $past(bus_req.wdata, 2) <= 16'h0001)
      else $error("counter write lost");
   a_capture_flag: assert property (
      en_r && cap_r && $rose(capture_in) |-> ##[1:8] irq)
      else $error("capture did not raise the flag");
endmodule // match_timer_checker

bind match_timer_channel match_timer_checker u_match_timer_checker (
   .ref_clk, .reset, .bus_req, .rdata, .capture_in, .match_a_irq_request
);

// ---- hw/count_tick_gen.sv ----
/*
 * Prescaler: produces a one-cycle count enable from the system clock at
 * the selected division.  Assumes the select is stable or that a glitch
 * of one short period after a change is acceptable.
 */
`timescale 1ns/1ps

module count_tick_gen (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic [2:0] div_sel,
   output logic            tick
);
   import match_timer_pkg::*;

   typedef struct packed {
      logic [PSC_WIDTH-1:0] cnt;
   } tick_state_type;

   tick_state_type s_r;
   tick_state_type s_nxt;
   logic [PSC_WIDTH-1:0] limit;

   // ------------------------------------------------------------------
   // Divider selection
   // ------------------------------------------------------------------
   function automatic logic [PSC_WIDTH-1:0] div_limit(input logic [2:0] sel);
      unique case (sel)
         3'h0: div_limit = DIV_1;
         3'h1: div_limit = DIV_4;
         3'h2: div_limit = DIV_16;
         3'h3: div_limit = DIV_64;
         3'h4: div_limit = DIV_1024;
         3'h5: div_limit = DIV_256;
         3'h6: div_limit = DIV_256;
         3'h7: div_limit = DIV_1024;
      endcase
   endfunction

   always_comb begin
      limit = div_limit(div_sel);
      s_nxt = s_r;
      tick  = (s_r.cnt >= limit);
      if (tick) begin
         s_nxt.cnt = '0;
      end else begin
         s_nxt.cnt = s_r.cnt + 10'h001;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // count_tick_gen

// ---- hw/match_timer_channel.sv ----
/*
 * One channel of a 16-bit compare/capture timer with its register port.
 * Assumes a register master on the same clock; capture_in is an
 * asynchronous pin and passes a three-stage synchroniser.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

module match_timer_channel (
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   input  wire match_timer_pkg::bus_req_type  bus_req,
   output logic [15:0]                        rdata,
   input  wire logic                          capture_in,
   output logic                               match_a_irq_request
);
   import match_timer_pkg::*;

   typedef struct packed {
      logic [7:0]  shared_run_control;
      logic [7:0]  channel_clocking_control;
      logic [7:0]  mode_control;
      logic [7:0]  channel_irq_enable;
      logic        match_a_flag;
      logic        flag_seen_set;
      logic [15:0] channel_counter;
      logic [15:0] compare_capture_value;
      logic [15:0] rdata;
      logic [2:0]  cap_sync;
      logic        cap_prev;
      logic        tick_prev;
   } chan_state_type;

   chan_state_type s_r;
   chan_state_type s_nxt;
   logic           tick;
   logic           count_edge;
   logic           capture_event;
   logic           capture_mode;
   logic           run;
   logic           match;
   logic           cnt_moved;
   logic [15:0]    cnt_work;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction

   // ------------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------------
   // prescale divider select
   count_tick_gen u_tick (
      .ref_clk (ref_clk),
      .reset   (reset),
      .div_sel (s_r.channel_clocking_control[PSC_HI_POS:PSC_LO_POS]),
      .tick    (tick)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      run = s_r.shared_run_control[RUN_BIT_POS];
      capture_mode = s_r.mode_control[CAPTURE_MODE_POS];

      // The tick is a one-cycle enable, so its rising and falling
      // versions are both single cycles; falling edge is one cycle later.
      // edge select
      unique case (s_r.channel_clocking_control[EDGE_HI_POS:EDGE_LO_POS])
         EDGE_RISING: count_edge = tick;
         2'h1:        count_edge = s_r.tick_prev;
         default:     count_edge = tick | s_r.tick_prev;
      endcase

      // Capture pin: stages 2 and 3 must agree before a rise counts.
      s_nxt.cap_sync = {s_r.cap_sync[1:0], capture_in};
      if (s_r.cap_sync[2] == s_r.cap_sync[1]) begin
         s_nxt.cap_prev = s_r.cap_sync[2];
      end
      capture_event = s_r.cap_sync[2] & (s_r.cap_sync[2] == s_r.cap_sync[1])
                      & ~s_r.cap_prev;
      s_nxt.tick_prev = tick;

      cnt_work  = s_r.channel_counter;
      cnt_moved = 1'b0;
      if (run && count_edge) begin
         cnt_moved = 1'b1;
         cnt_work  = s_r.channel_counter + COUNT_STEP;
         // clear on match
         // The counter rests on the compare value for one count period and
         // clears on the next count, so a match period is the value plus one.
         if (!capture_mode
             && s_r.channel_clocking_control[CLR_HI_POS:CLR_LO_POS] == CLEAR_ON_MATCH
             && hit(s_r.channel_counter, s_r.compare_capture_value)) begin
            cnt_work = COUNTER_RESET;
         end
      end
      if (bus_req.wr && bus_req.addr == OFS_COUNTER) begin
         cnt_moved = 1'b1;
         cnt_work  = bus_req.wdata;
      end
      // Only a count or a counter write can match, so a counter resting on the
      // compare value does not set the flag again right after a clear.
      match = !capture_mode && cnt_moved && hit(cnt_work, s_r.compare_capture_value);
      s_nxt.channel_counter = cnt_work;

      if (bus_req.wr && bus_req.addr == OFS_COMPARE) begin
         s_nxt.compare_capture_value = bus_req.wdata;
      end
      if (capture_mode && capture_event) begin
         s_nxt.compare_capture_value = s_r.channel_counter;
      end

      // Plain control writes.
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            OFS_RUN_CTRL:   s_nxt.shared_run_control       = bus_req.wdata[7:0];
            OFS_CLK_CTRL:   s_nxt.channel_clocking_control = bus_req.wdata[7:0];
            OFS_MODE_CTRL:  s_nxt.mode_control             = bus_req.wdata[7:0];
            OFS_IRQ_ENABLE: s_nxt.channel_irq_enable       = bus_req.wdata[7:0];
            default: ;
         endcase
      end

      if (bus_req.rd && bus_req.addr == OFS_EVT_STATUS && s_r.match_a_flag) begin
         s_nxt.flag_seen_set = 1'b1;
      end
      if (bus_req.wr && bus_req.addr == OFS_EVT_STATUS
          && !bus_req.wdata[MATCH_A_POS] && s_r.flag_seen_set) begin
         s_nxt.match_a_flag  = 1'b0;
         s_nxt.flag_seen_set = 1'b0;
      end
      // set on compare; set wins over a clear in the same cycle.
      if (match || (capture_mode && capture_event)) begin
         s_nxt.match_a_flag = 1'b1;
      end

      // Read data, one cycle after the strobe. Unmapped reads give zero.
      s_nxt.rdata = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_RUN_CTRL:   s_nxt.rdata = {8'h00, s_r.shared_run_control};
            OFS_CLK_CTRL:   s_nxt.rdata = {8'h00, s_r.channel_clocking_control};
            OFS_MODE_CTRL:  s_nxt.rdata = {8'h00, s_r.mode_control};
            OFS_IRQ_ENABLE: s_nxt.rdata = {8'h00, s_r.channel_irq_enable};
            OFS_EVT_STATUS: s_nxt.rdata = {15'h0000, s_r.match_a_flag};
            OFS_COUNTER:    s_nxt.rdata = s_r.channel_counter;
            OFS_COMPARE:    s_nxt.rdata = s_r.compare_capture_value;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_r                       <= '0;
         s_r.compare_capture_value <= COMPARE_RESET;
         s_r.channel_counter       <= COUNTER_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign rdata = s_r.rdata;
   assign match_a_irq_request = s_r.match_a_flag & s_r.channel_irq_enable[MATCH_A_POS];

endmodule // match_timer_channel

// ---- hw/match_timer_pkg.sv ----
/*
 * Package for the compare/capture timer channel: register map, field
 * positions, reset values, prescaler divisors and the bus carrier struct.
 * Assumes a single 100 MHz clock and a 16-bit register port.
 */
package match_timer_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [15:0] OFS_RUN_CTRL    = 16'hf030;
   localparam logic [15:0] OFS_CLK_CTRL    = 16'hf040;
   localparam logic [15:0] OFS_MODE_CTRL   = 16'hf041;
   localparam logic [15:0] OFS_IRQ_ENABLE  = 16'hf044;
   localparam logic [15:0] OFS_EVT_STATUS  = 16'hf045;
   localparam logic [15:0] OFS_COUNTER     = 16'hf046;
   localparam logic [15:0] OFS_COMPARE     = 16'hf048;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int RUN_BIT_POS       = 1;
   localparam int MATCH_A_POS       = 0;
   localparam int CAPTURE_MODE_POS  = 0;
   localparam int CLR_HI_POS        = 6;
   localparam int CLR_LO_POS        = 5;
   localparam int EDGE_HI_POS       = 4;
   localparam int EDGE_LO_POS       = 3;
   localparam int PSC_HI_POS        = 2;
   localparam int PSC_LO_POS        = 0;

   localparam logic [1:0] CLEAR_ON_MATCH = 2'h1;
   localparam logic [1:0] EDGE_RISING    = 2'h0;
   localparam logic [2:0] PSC_DIV256     = 3'h6;

   // ------------------------------------------------------------------
   // Reset values and the count step
   // ------------------------------------------------------------------
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'hffff;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [15:0] COUNT_STEP    = 16'h0001;

   // Prescaler divisors, indexed by the three select bits.
   localparam int PSC_WIDTH = 10;
   localparam logic [PSC_WIDTH-1:0] DIV_1    = 10'h000;
   localparam logic [PSC_WIDTH-1:0] DIV_4    = 10'h003;
   localparam logic [PSC_WIDTH-1:0] DIV_16   = 10'h00f;
   localparam logic [PSC_WIDTH-1:0] DIV_64   = 10'h03f;
   localparam logic [PSC_WIDTH-1:0] DIV_256  = 10'h0ff;
   localparam logic [PSC_WIDTH-1:0] DIV_1024 = 10'h3ff;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;

endpackage : match_timer_pkg
